// file: wrs_pkg.sv
// constants shared by the wiper command target and its bus controller
// assumes both ends run on one 20 MHz system clock
package wrs_pkg;
  // command byte operation codes
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_INC = 2'h1;
  localparam logic [1:0] OP_DEC = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;
  // command byte field positions
  localparam int CMD_ADDR_LSB = 4;
  localparam int CMD_OP_LSB = 2;
  localparam int CMD_D8_BIT = 0;
  // target memory locations
  localparam logic [3:0] LOC_WIPER0 = 4'h0;
  localparam logic [3:0] LOC_WIPER1 = 4'h1;
  localparam logic [3:0] LOC_TCON = 4'h4;
  localparam logic [3:0] LOC_STATUS = 4'h5;
  // wiper scale points and reset values
  localparam logic [8:0] FULL_8BIT = 9'h100;
  localparam logic [8:0] FULL_7BIT = 9'h080;
  localparam logic [8:0] ZERO_SCALE = 9'h000;
  localparam logic [8:0] WIPER_RESET = 9'h080;
  localparam logic [8:0] TCON_RESET = 9'h1ff;
  localparam logic [8:0] STATUS_VALUE = 9'h000;
  localparam logic [3:0] PTR_RESET = 4'h0;
  localparam logic [6:0] BUS_ADDR = 7'h2e;
  // controller register offsets and fields
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_WDATA = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_RDATA = 4'hc;
  localparam int CMD_GO_BIT = 8;
  localparam int CMD_HV_BIT = 7;
  localparam int CMD_WD8_BIT = 6;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // controller sequence steps
  localparam logic [3:0] ST_START = 4'h0;
  localparam logic [3:0] ST_CTRL_W = 4'h1;
  localparam logic [3:0] ST_CMD = 4'h2;
  localparam logic [3:0] ST_DATA = 4'h3;
  localparam logic [3:0] ST_RSTART = 4'h4;
  localparam logic [3:0] ST_CTRL_R = 4'h5;
  localparam logic [3:0] ST_RX_HI = 4'h6;
  localparam logic [3:0] ST_RX_LO = 4'h7;
  localparam logic [3:0] ST_STOP = 4'h8;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCL_PERIOD_NS = 1000;
  localparam int QUARTER_CYCLES = SCL_PERIOD_NS / CLK_PERIOD_NS / 4;
  localparam int HV_SETUP_NS = 1000;
  localparam int HV_SETUP_CYCLES =
    (HV_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// file: wrs_link_if.sv
// two-wire link between the wiper target and the bus controller
// resolves the open-drain wires from the drivers' enables
interface wrs_link_if;
  logic scl_o;
  logic scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic high_voltage_cmd_select;
  logic address_pin_zero;
  logic scl;
  logic sda;

  // wired-and with pull-ups; both parties drive sda, only the controller drives scl
  assign scl = !(scl_oe && !scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) ||
                 (dev_sda_oe && !dev_sda_o));

  modport target (
    input scl, sda, high_voltage_cmd_select, address_pin_zero,
    output dev_sda_o, dev_sda_oe
  );
  modport controller (
    input sda,
    output scl_o, scl_oe, host_sda_o, host_sda_oe,
    output high_voltage_cmd_select, address_pin_zero
  );
endinterface

// file: wrs_sync.sv
// two-flop synchroniser with edge detection for a link pin
// assumes the pin idles high, as a pulled-up wire does
module wrs_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // pin and results
  input wire logic d,
  output logic lvl,
  output logic rise,
  output logic fall
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // capture chain; edges look only at the second and third flops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end
    else if (ce)
    begin
      meta_reg <= d;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // level and one-cycle edge strobes
  assign lvl = sync_reg;
  assign rise = sync_reg && !last_reg;
  assign fall = !sync_reg && last_reg;
endmodule

// file: wrs_target.sv
// wiper command target: the device end of the two-wire link
// assumes scl, sda and the address pins arrive unsynchronised
// Operation
// - master reads: write control, command, restart, read control
// - read returns high byte then low byte
// - read uses last valid command address, else 00h
// - address pointer survives stop conditions
// - master ends single read with stop or restart
// - acked bytes continue reading; nack ends it
// - reads everywhere; volatile only while nonvolatile busy; code accepts reads only at 00h, 01h, 04h, 05h
// - invalid command releases data, ignores until start
// - increment and decrement only at 00h, 01h
// - increment adds one, saturates at full scale
// - decrement subtracts one, saturates at zero
// - wiper steps during the command acknowledge
// - reserved values above full scale never step
// - step may be followed by any command
// - high voltage on address pin selects mode
// - master waits after raising high voltage
// - command byte: address, operation, data bit nine
// - invalid combination not acknowledged, later ignored
// - write joins data bit nine with data byte
//
// Implementation choice: no register bus here; the AXI4-Lite slave port is in wrs_controller.
module wrs_target
  import wrs_pkg::*;
#(
  parameter bit EIGHT_BIT = 1'b1,
  parameter logic [6:0] DEV_ADDR = BUS_ADDR
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // link
  wrs_link_if.target link,
  // user side
  input wire logic nv_busy,
  output logic [8:0] wiper_zero_setting,
  output logic [8:0] wiper_one_setting,
  output logic [8:0] tcon_setting,
  output logic hv_mode
);
  typedef enum logic [3:0] {
    T_IDLE, T_CTRL, T_CTRL_ACK, T_CMD, T_CMD_ACK,
    T_DATA, T_DATA_ACK, T_TX, T_TX_ACK, T_IGNORE
  } wrs_tstate_t;

  localparam logic [8:0] FULL = EIGHT_BIT ? FULL_8BIT : FULL_7BIT;

  wrs_tstate_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic oe_reg, oe_next;
  logic [3:0] ptr_reg, ptr_next;
  logic d8_reg, d8_next;
  logic rw_reg, rw_next;
  logic hi_reg, hi_next;
  logic hv_reg, hv_next;
  logic [8:0] wiper_reg [2];
  logic [8:0] tcon_reg;
  logic wip_we;
  logic tcon_we;
  logic [8:0] wr_val;
  logic [7:0] tb;
  logic scl_lvl, scl_rise, scl_fall;
  logic sda_lvl, sda_rise, sda_fall;
  logic a0_lvl, hv_lvl;

  // link pins pass two flops before use
  wrs_sync u_scl (.clk(clk), .rst(rst), .ce(ce), .d(link.scl),
    .lvl(scl_lvl), .rise(scl_rise), .fall(scl_fall));
  wrs_sync u_sda (.clk(clk), .rst(rst), .ce(ce), .d(link.sda),
    .lvl(sda_lvl), .rise(sda_rise), .fall(sda_fall));
  wrs_sync u_a0 (.clk(clk), .rst(rst), .ce(ce),
    .d(link.address_pin_zero), .lvl(a0_lvl), .rise(), .fall());
  wrs_sync u_hv (.clk(clk), .rst(rst), .ce(ce),
    .d(link.high_voltage_cmd_select), .lvl(hv_lvl), .rise(), .fall());

  // saturating wiper step
  function automatic logic [8:0] wrs_step(input logic [8:0] v,
    input logic up);
    if (v > FULL)
      wrs_step = v;
    else if (up)
      wrs_step = (v == FULL) ? v : v + 9'h001;
    else
      wrs_step = (v == ZERO_SCALE) ? v : v - 9'h001;
  endfunction

  // bus conditions and command byte fields
  wire start_det = sda_fall && scl_lvl;
  wire stop_det = sda_rise && scl_lvl;
  wire [3:0] c_addr = sh_reg[CMD_ADDR_LSB +: 4];
  wire [1:0] c_op = sh_reg[CMD_OP_LSB +: 2];
  wire c_wiper = (c_addr == LOC_WIPER0) || (c_addr == LOC_WIPER1);
  wire c_vol = c_wiper || (c_addr == LOC_TCON);
  wire c_step = (c_op == OP_INC) || (c_op == OP_DEC);
  wire rd_ok = c_vol || ((c_addr == LOC_STATUS) && !nv_busy);
  wire cmd_ok = c_step ? c_wiper :
                (c_op == OP_WRITE) ? c_vol : rd_ok;
  wire addr_hit = sh_reg[7:1] == {DEV_ADDR[6:1], a0_lvl | hv_lvl};
  wire byte_done = cnt_reg == 4'h8;

  // value behind the pointer, split into two bytes
  wire [8:0] rd_val = (ptr_reg == LOC_WIPER0) ? wiper_reg[0] :
                      (ptr_reg == LOC_WIPER1) ? wiper_reg[1] :
                      (ptr_reg == LOC_TCON) ? tcon_reg :
                      (ptr_reg == LOC_STATUS) ? STATUS_VALUE : 9'h000;
  wire [7:0] rd_hi = {7'h00, rd_val[8]};
  wire [7:0] rd_lo = rd_val[7:0];

  // protocol engine, advanced by link edges
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    oe_next = oe_reg;
    ptr_next = ptr_reg;
    d8_next = d8_reg;
    rw_next = rw_reg;
    hi_next = hi_reg;
    hv_next = hv_reg;
    wip_we = 1'b0;
    tcon_we = 1'b0;
    wr_val = 9'h000;
    tb = rd_hi;
    if (start_det)
    begin
      state_next = T_CTRL;
      cnt_next = 4'h0;
      oe_next = 1'b0;
      hv_next = hv_lvl;
    end
    else if (stop_det)
    begin
      state_next = T_IDLE;
      oe_next = 1'b0;
    end
    else if (scl_rise)
    begin
      case (state_reg)
        T_CTRL, T_CMD, T_DATA:
          if (!byte_done)
          begin
            sh_next = {sh_reg[6:0], sda_lvl};
            cnt_next = cnt_reg + 4'h1;
          end
        T_TX_ACK:
          if (sda_lvl)
            state_next = T_IGNORE;
          else
          begin
            state_next = T_TX;
            hi_next = !hi_reg;
            sh_next = hi_reg ? rd_lo : rd_hi;
            cnt_next = 4'h0;
          end
        default: ;
      endcase
    end
    else if (scl_fall)
    begin
      case (state_reg)
        T_CTRL:
          if (byte_done)
          begin
            oe_next = addr_hit;
            rw_next = sh_reg[0];
            state_next = addr_hit ? T_CTRL_ACK : T_IGNORE;
          end
        T_CMD:
          if (byte_done)
          begin
            oe_next = cmd_ok;
            state_next = cmd_ok ? T_CMD_ACK : T_IGNORE;
            if (cmd_ok)
            begin
              ptr_next = c_addr;
              d8_next = sh_reg[CMD_D8_BIT];
              wip_we = c_step;
              wr_val = wrs_step(wiper_reg[c_addr[0]], c_op == OP_INC);
            end
          end
        T_DATA:
          if (byte_done)
          begin
            oe_next = 1'b1;
            state_next = T_DATA_ACK;
            wr_val = {d8_reg, sh_reg};
            wip_we = ptr_reg != LOC_TCON;
            tcon_we = ptr_reg == LOC_TCON;
          end
        T_CTRL_ACK:
          if (rw_reg)
          begin
            state_next = T_TX;
            hi_next = 1'b1;
            tb = rd_hi;
            oe_next = !tb[7];
            sh_next = {tb[6:0], 1'b0};
            cnt_next = 4'h1;
          end
          else
          begin
            state_next = T_CMD;
            oe_next = 1'b0;
            cnt_next = 4'h0;
          end
        T_CMD_ACK:
        begin
          oe_next = 1'b0;
          cnt_next = 4'h0;
          state_next = (c_op == OP_WRITE) ? T_DATA : T_CMD;
        end
        T_DATA_ACK:
        begin
          oe_next = 1'b0;
          cnt_next = 4'h0;
          state_next = T_CMD;
        end
        T_TX:
          if (byte_done)
          begin
            oe_next = 1'b0;
            state_next = T_TX_ACK;
          end
          else
          begin
            oe_next = !sh_reg[7];
            sh_next = {sh_reg[6:0], 1'b0};
            cnt_next = cnt_reg + 4'h1;
          end
        default: ;
      endcase
    end
  end

  // protocol state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= T_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      oe_reg <= 1'b0;
      ptr_reg <= PTR_RESET;
      d8_reg <= 1'b0;
      rw_reg <= 1'b0;
      hi_reg <= 1'b1;
      hv_reg <= 1'b0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      oe_reg <= oe_next;
      ptr_reg <= ptr_next;
      d8_reg <= d8_next;
      rw_reg <= rw_next;
      hi_reg <= hi_next;
      hv_reg <= hv_next;
    end
  end

  // volatile registers, indexed by the low address bit
  wire wsel = wip_we && state_reg == T_CMD ? c_addr[0] : ptr_reg[0];
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wiper_reg[0] <= WIPER_RESET;
      wiper_reg[1] <= WIPER_RESET;
      tcon_reg <= TCON_RESET;
    end
    else if (ce)
    begin
      if (wip_we)
        wiper_reg[wsel] <= wr_val;
      if (tcon_we)
        tcon_reg <= wr_val;
    end
  end

  // outputs; data line is open drain, low when enabled
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = oe_reg;
  assign wiper_zero_setting = wiper_reg[0];
  assign wiper_one_setting = wiper_reg[1];
  assign tcon_setting = tcon_reg;
  assign hv_mode = hv_reg;
endmodule

// file: wrs_controller.sv
// bus controller end: runs one wiper command per software order
// assumes an AXI4-Lite master on the system clock
module wrs_controller
  import wrs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = BUS_ADDR,
  parameter int QUARTER = QUARTER_CYCLES,
  parameter int HV_WAIT = HV_SETUP_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register bus
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [3:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // link
  wrs_link_if.controller link
);
  typedef enum logic {H_IDLE, H_RUN} wrs_hstate_t;

  wrs_hstate_t st_reg;
  logic aw_reg, w_reg, bv_reg, rv_reg;
  logic [3:0] awa_reg;
  logic [31:0] wd_reg, rd_reg;
  logic [1:0] br_reg, rr_reg;
  logic [8:0] cmd_reg;
  logic [7:0] wdat_reg, sh_reg;
  logic [9:0] rdat_reg;
  logic nack_reg, scl_reg, sda_reg;
  logic [3:0] step_reg, bit_reg;
  logic [1:0] q_reg;
  logic [15:0] qc_reg;
  logic sda_lvl;

  // data line read back through two flops
  wrs_sync u_sda (.clk(clk), .rst(rst), .ce(ce), .d(link.sda),
    .lvl(sda_lvl), .rise(), .fall());

  // bus decode
  wire wr_go = aw_reg && w_reg && !bv_reg;
  wire wr_map = (awa_reg == REG_CMD) || (awa_reg == REG_WDATA);
  wire go = wr_go && awa_reg == REG_CMD && s_axi_wstrb[1] &&
            wd_reg[CMD_GO_BIT] && st_reg == H_IDLE;
  wire ar_take = s_axi_arvalid && !rv_reg;
  wire [31:0] rd_mux = (s_axi_araddr == REG_CMD) ? {23'h0, cmd_reg} :
    (s_axi_araddr == REG_WDATA) ? {24'h0, wdat_reg} :
    (s_axi_araddr == REG_STATUS) ? {30'h0, nack_reg, st_reg == H_RUN} :
    {22'h0, rdat_reg};
  wire rd_map = s_axi_araddr[1:0] == 2'h0;

  // sequencer decode
  wire tick = st_reg == H_RUN && qc_reg == 16'h0;
  wire [1:0] op = cmd_reg[1:0];
  wire is_cond = step_reg == ST_START || step_reg == ST_RSTART ||
                 step_reg == ST_STOP;
  wire is_rx = step_reg == ST_RX_HI || step_reg == ST_RX_LO;
  // address bit zero reads high while the high-voltage select is up
  wire [6:0] addr_hv = {DEV_ADDR[6:1], DEV_ADDR[0] | cmd_reg[CMD_HV_BIT]};
  wire [7:0] tx_byte_cmd = {cmd_reg[5:2], op, 1'b0, cmd_reg[CMD_WD8_BIT]};
  wire [3:0] after_cmd = (op == OP_WRITE) ? ST_DATA :
                         (op == OP_READ) ? ST_RSTART : ST_STOP;
  wire [3:0] step_nx = (step_reg == ST_CMD) ? after_cmd :
    (step_reg == ST_DATA || step_reg == ST_RX_LO) ? ST_STOP :
    step_reg + 4'h1;
  wire bit_sda = is_rx ? (bit_reg != 4'h8 || step_reg == ST_RX_LO) :
                 (bit_reg == 4'h8 || sh_reg[7]);
  // byte to send at the next step
  wire [7:0] tx_byte_nx = (step_nx == ST_CTRL_W) ? {addr_hv, 1'b0} :
    (step_nx == ST_CTRL_R) ? {addr_hv, 1'b1} :
    (step_nx == ST_CMD) ? tx_byte_cmd : wdat_reg;

  // register bus slave
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {aw_reg, w_reg, bv_reg, rv_reg} <= 4'h0;
      awa_reg <= 4'h0;
      wd_reg <= 32'h0;
      rd_reg <= 32'h0;
      br_reg <= AXI_OKAY;
      rr_reg <= AXI_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_reg <= 1'b1;
        awa_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_reg <= 1'b1;
        wd_reg <= s_axi_wdata;
      end
      if (wr_go)
      begin
        {aw_reg, w_reg, bv_reg} <= 3'b001;
        br_reg <= wr_map ? AXI_OKAY : AXI_SLVERR;
      end
      else if (bv_reg && s_axi_bready)
        bv_reg <= 1'b0;
      if (ar_take)
      begin
        rv_reg <= 1'b1;
        rd_reg <= rd_map ? rd_mux : 32'h0;
        rr_reg <= rd_map ? AXI_OKAY : AXI_SLVERR;
      end
      else if (rv_reg && s_axi_rready)
        rv_reg <= 1'b0;
    end
  end

  // command registers and the bit-level sequencer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= H_IDLE;
      cmd_reg <= 9'h000;
      wdat_reg <= 8'h00;
      rdat_reg <= 10'h000;
      nack_reg <= 1'b0;
      {scl_reg, sda_reg} <= 2'b11;
      step_reg <= ST_START;
      bit_reg <= 4'h0;
      q_reg <= 2'h0;
      qc_reg <= 16'h0;
      sh_reg <= 8'h00;
    end
    else if (ce)
    begin
      if (wr_go && awa_reg == REG_WDATA && s_axi_wstrb[0])
        wdat_reg <= wd_reg[7:0];
      if (go)
      begin
        cmd_reg <= {1'b0, wd_reg[7:0]};
        st_reg <= H_RUN;
        nack_reg <= 1'b0;
        step_reg <= ST_START;
        q_reg <= 2'h0;
        qc_reg <= wd_reg[CMD_HV_BIT] ? 16'(HV_WAIT) : 16'(QUARTER - 1);
      end
      else if (st_reg == H_RUN)
      begin
        qc_reg <= tick ? 16'(QUARTER - 1) : qc_reg - 16'h1;
        if (tick)
        begin
          q_reg <= q_reg + 2'h1;
          case (q_reg)
            2'h0:
              sda_reg <= is_cond ? step_reg != ST_STOP : bit_sda;
            2'h1:
              scl_reg <= 1'b1;
            2'h2:
              if (is_cond)
                sda_reg <= step_reg == ST_STOP;
              else if (is_rx && bit_reg != 4'h8)
                rdat_reg <= {rdat_reg[8:0], sda_lvl};
              else if (!is_rx && bit_reg == 4'h8 && sda_lvl)
                nack_reg <= 1'b1;
            default:
            begin
              scl_reg <= step_reg == ST_STOP;
              if (step_reg == ST_STOP)
                st_reg <= H_IDLE;
              else if (is_cond || bit_reg == 4'h8)
              begin
                bit_reg <= 4'h0;
                step_reg <= (nack_reg && !is_rx) ? ST_STOP : step_nx;
                sh_reg <= (step_nx == ST_STOP) ? 8'hff : tx_byte_nx;
              end
              else
              begin
                bit_reg <= bit_reg + 4'h1;
                sh_reg <= {sh_reg[6:0], 1'b1};
              end
            end
          endcase
        end
      end
    end
  end

  // bus and link outputs
  assign s_axi_awready = !aw_reg && !bv_reg;
  assign s_axi_wready = !w_reg && !bv_reg;
  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = br_reg;
  assign s_axi_arready = !rv_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata = rd_reg;
  assign s_axi_rresp = rr_reg;
  assign link.scl_o = 1'b0;
  assign link.scl_oe = !scl_reg;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = !sda_reg;
  assign link.high_voltage_cmd_select = st_reg == H_RUN && cmd_reg[CMD_HV_BIT];
  assign link.address_pin_zero = DEV_ADDR[0];
endmodule

// file: wrs_link_assertions.sv
// checker for the two-wire link between the controller and the target
// assumes it sees the link interface signals on the controller clock
module wrs_link_assertions
  import wrs_pkg::*;
#(
  parameter int HV_WAIT = HV_SETUP_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // controller drivers
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic high_voltage_cmd_select,
  input wire logic address_pin_zero,
  // target drivers
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  // resolved wires
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hv_cnt_reg;
  logic [7:0] hv_cnt_next;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // cycles since the high-voltage select went high, saturating
  assign hv_cnt_next = !high_voltage_cmd_select ? 8'h00 :
    (hv_cnt_reg == 8'hff) ? 8'hff : hv_cnt_reg + 8'h01;

  always_ff @(posedge clk or posedge rst)
    if (rst)
      hv_cnt_reg <= 8'h00;
    else
      hv_cnt_reg <= hv_cnt_next;

  // open-drain drivers only ever pull low
  dev_drive_low_a: assert property (
    dev_sda_oe |-> !dev_sda_o)
    else $error("target drives sda high");
  host_drive_low_a: assert property (
    (host_sda_oe |-> !host_sda_o) and (scl_oe |-> !scl_o))
    else $error("controller drives a wire high");
  // target changes sda only well inside the scl low phase
  dev_scl_low_a: assert property (
    $changed(dev_sda_oe) |-> !scl)
    else $error("target moved sda while scl high");
  dev_settle_a: assert property (
    $rose(dev_sda_oe) |-> !$past(scl) && !$past(scl, 2))
    else $error("target drove sda too soon after scl fell");
  dev_fall_hold_a: assert property (
    $fell(scl) |=> $stable(dev_sda_oe))
    else $error("target moved sda on the scl fall itself");
  // a start leaves the target listening, not driving
  start_release_a: assert property (
    (scl && $past(scl) && $fell(sda)) |-> !dev_sda_oe [*8])
    else $error("target drives sda after a start");
  // first scl edge waits for the high-voltage setup
  hv_wait_a: assert property (
    ($rose(scl_oe) && high_voltage_cmd_select) |-> hv_cnt_reg >= HV_WAIT)
    else $error("scl moved too soon after high voltage");
  addr_pin_a: assert property (
    $stable(address_pin_zero))
    else $error("address pin changed");
  hv_frame_a: assert property (
    !scl |-> $stable(high_voltage_cmd_select))
    else $error("high voltage select changed inside a frame");
endmodule

// file: wiper_read_step_cmd_bench.sv
// bench: controller and wiper target joined over the link interface
// assumes software orders over AXI4-Lite on a 20 MHz clock
module wiper_read_step_cmd_bench
  import wrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // clock, reset and target user side
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic nv_busy = 1'b0;
  logic [8:0] wiper_zero_setting;
  logic [8:0] wiper_one_setting;
  logic [8:0] tcon_setting;
  logic hv_mode;
  // register bus
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [1:0] s_axi_bresp;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [3:0] s_axi_araddr = 4'h0;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  int miscompares = 0;
  int tests_run = 0;

  always #25 clk = ~clk;

  // both ends, the link between them and its checker
  wrs_link_if i_wrs_link_if ();
  wrs_target i_wrs_target (.clk(clk), .rst(rst), .ce(1'b1),
    .link(i_wrs_link_if), .nv_busy(nv_busy),
    .wiper_zero_setting(wiper_zero_setting),
    .wiper_one_setting(wiper_one_setting),
    .tcon_setting(tcon_setting), .hv_mode(hv_mode));
  wrs_controller i_wrs_controller (.clk(clk), .rst(rst), .ce(1'b1),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .link(i_wrs_link_if));
  wrs_link_assertions #(.HV_WAIT(HV_SETUP_CYCLES)) i_wrs_link_assertions (
    .clk(clk), .rst(rst), .scl_o(i_wrs_link_if.scl_o),
    .scl_oe(i_wrs_link_if.scl_oe), .host_sda_o(i_wrs_link_if.host_sda_o),
    .host_sda_oe(i_wrs_link_if.host_sda_oe),
    .high_voltage_cmd_select(i_wrs_link_if.high_voltage_cmd_select),
    .address_pin_zero(i_wrs_link_if.address_pin_zero),
    .dev_sda_o(i_wrs_link_if.dev_sda_o),
    .dev_sda_oe(i_wrs_link_if.dev_sda_oe),
    .scl(i_wrs_link_if.scl), .sda(i_wrs_link_if.sda));

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one register write, address and data offered together
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
    output logic [1:0] r);
    logic aw;
    logic w;
    logic b;
    b = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b)
    begin
      @(negedge clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = (s_axi_bvalid === 1'b1);
      r = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
  endtask

  // one register read
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
    output logic [1:0] r);
    logic ar;
    logic v;
    v = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!v)
    begin
      @(negedge clk);
      ar = s_axi_arvalid && s_axi_arready;
      v = (s_axi_rvalid === 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (v) s_axi_rready <= 1'b0;
    end
  endtask

  // run one command; f = {hv, d8, nack expected}; sel picks the result
  task automatic step(input logic [1:0] op, input logic [3:0] loc,
    input logic [2:0] f, input logic [7:0] wd, input logic [1:0] sel,
    input logic [9:0] exp);
    logic [31:0] v;
    logic [1:0] r;
    axi_wr(REG_WDATA, {24'h0, wd}, r);
    axi_wr(REG_CMD, {23'h0, 1'b1, f[2], f[1], loc, op}, r);
    v = 32'h1;
    while (v[0] !== 1'b0)
      axi_rd(REG_STATUS, v, r);
    chk({31'h0, v[1]}, {31'h0, f[0]});
    chk({31'h0, hv_mode}, {31'h0, f[2]});
    case (sel)
      2'h0: v = {23'h0, wiper_zero_setting};
      2'h1: v = {23'h0, wiper_one_setting};
      2'h2: v = {23'h0, tcon_setting};
      default: axi_rd(REG_RDATA, v, r);
    endcase
    chk(v, {22'h0, exp});
  endtask

  // watchdog against a hung transfer
  initial
  begin
    #3000000;
    miscompares++;
    results();
  end

  // main sequence
  initial
  begin
    logic [31:0] v;
    logic [1:0] r;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk({23'h0, wiper_zero_setting}, {23'h0, WIPER_RESET});
    chk({23'h0, tcon_setting}, {23'h0, TCON_RESET});
    axi_rd(4'h2, v, r);
    chk(v, 32'h0);
    chk({30'h0, r}, {30'h0, AXI_SLVERR});
    axi_wr(4'h6, 32'h0, r);
    chk({30'h0, r}, {30'h0, AXI_SLVERR});
    step(OP_WRITE, LOC_WIPER0, 3'h0, 8'hff, 2'h0, 10'h0ff);
    repeat (2) step(OP_INC, LOC_WIPER0, 3'h0, 8'h00, 2'h0, 10'h100);
    step(OP_READ, LOC_WIPER0, 3'h0, 8'h00, 2'h3, 10'h100);
    step(OP_WRITE, LOC_WIPER1, 3'h0, 8'h01, 2'h1, 10'h001);
    repeat (2) step(OP_DEC, LOC_WIPER1, 3'h0, 8'h00, 2'h1, 10'h000);
    step(OP_WRITE, LOC_WIPER0, 3'h2, 8'hff, 2'h0, 10'h1ff);
    step(OP_INC, LOC_WIPER0, 3'h0, 8'h00, 2'h0, 10'h1ff);
    step(OP_DEC, LOC_WIPER0, 3'h0, 8'h00, 2'h0, 10'h1ff);
    step(OP_WRITE, LOC_TCON, 3'h0, 8'h5a, 2'h2, 10'h05a);
    step(OP_INC, LOC_TCON, 3'h1, 8'h00, 2'h2, 10'h05a);
    step(OP_DEC, 4'h7, 3'h1, 8'h00, 2'h0, 10'h1ff);
    step(OP_READ, LOC_WIPER1, 3'h0, 8'h00, 2'h3, 10'h000);
    step(OP_READ, LOC_TCON, 3'h0, 8'h00, 2'h3, 10'h05a);
    nv_busy <= 1'b1;
    step(OP_READ, LOC_STATUS, 3'h1, 8'h00, 2'h0, 10'h1ff);
    nv_busy <= 1'b0;
    step(OP_READ, LOC_STATUS, 3'h0, 8'h00, 2'h3, {1'b0, STATUS_VALUE});
    step(OP_INC, LOC_WIPER1, 3'h4, 8'h00, 2'h1, 10'h001);
    step(OP_DEC, LOC_WIPER1, 3'h0, 8'h00, 2'h1, 10'h000);
    results();
  end
endmodule
